/* File: design/tpsec_top.sv */
// Top of the T1 path and sync error counters with a classic Wishbone register slave.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module tpsec_top #(
  parameter int unsigned LONG_CYCLES  = tpsec_pkg::LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = tpsec_pkg::SHORT_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [0:0] wb_sel_i,
  input  wire logic [7:0] wb_dat_i,
  output logic [7:0]      wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic       crc6_error_i,
  input  wire logic       ft_error_i,
  input  wire logic       fs_error_i,
  input  wire logic       fps_error_i,
  input  wire logic       rx_multiframe_i,
  input  wire logic       receive_sync_loss_flag_i,
  output logic            boundary_o,
  output logic            irq_o
);
  logic [3:0]  ctrl_r;
  logic [2:0]  int_stat_r;
  logic [2:0]  int_mask_r;
  logic [11:0] path_latch_r;
  logic [11:0] sync_latch_r;
  logic        tick;
  logic [11:0] path_count;
  logic [11:0] sync_count;
  logic        path_sat;
  logic        sync_sat;

  wire framing_mode_select = ctrl_r[tpsec_pkg::CTRL_FRAMING];
  wire fs_count_enable     = ctrl_r[tpsec_pkg::CTRL_FS_EN];
  wire count_source_select = ctrl_r[tpsec_pkg::CTRL_SRC_SEL];
  wire interval_select     = ctrl_r[tpsec_pkg::CTRL_INTERVAL];

  // Path source: CRC6 in ESF regardless of the Fs option, Ft with optional Fs in D4.
  wire path_evt = framing_mode_select ? crc6_error_i : // [RULE4]
                  (ft_error_i || (fs_error_i && fs_count_enable)); // [RULE5]
  wire path_inc = path_evt && !receive_sync_loss_flag_i; // [RULE10]

  // Out-of-sync multiframes count only while the sync loss flag is set; framing-bit errors only while it is clear.
  wire mos_inc  = rx_multiframe_i && receive_sync_loss_flag_i; // [RULE6] [RULE7]
  wire fbit_evt = framing_mode_select ? fps_error_i : ft_error_i; // [RULE8]
  wire fbit_inc = fbit_evt && !receive_sync_loss_flag_i; // [RULE9]
  wire sync_inc = count_source_select ? mos_inc : fbit_inc;

  tpsec_interval_timer #(
    .LONG_CYCLES  (LONG_CYCLES),
    .SHORT_CYCLES (SHORT_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .short_i (interval_select),
    .tick_o  (tick)
  );

  // Each counter has its own instance of the saturating core: index 0 is the path count, index 1 the sync count.
  logic [1:0]  cnt_inc;
  logic [11:0] cnt_value [2];
  logic [1:0]  cnt_sat;

  assign cnt_inc = {sync_inc, path_inc};

  for (genvar g = 0; g < 2; g++) begin : g_counter
    tpsec_sat_counter u_counter (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .inc_i   (cnt_inc[g]),
      .clear_i (tick),
      .count_o (cnt_value[g]),
      .sat_o   (cnt_sat[g])
    );
  end

  assign path_count = cnt_value[0];
  assign sync_count = cnt_value[1];
  assign path_sat   = cnt_sat[0];
  assign sync_sat   = cnt_sat[1];

  // Latches hold the previous interval so reads stay stable until the next boundary.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      path_latch_r <= 12'h000;
      sync_latch_r <= 12'h000;
    end else if (tick) begin
      path_latch_r <= path_count; // [RULE13] [RULE11]
      sync_latch_r <= sync_count; // [RULE13]
    end
  end

  // Register access decode.
  wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // A write lands at the edge at which the master samples ack high, while it still holds the data.
  wire        wr       = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire        wr_ctrl  = wr && (wb_adr_i == tpsec_pkg::ADDR_CTRL);
  wire        wr_stat  = wr && (wb_adr_i == tpsec_pkg::ADDR_INT_STAT);
  wire        wr_mask  = wr && (wb_adr_i == tpsec_pkg::ADDR_INT_MASK);
  wire [7:0]  path_error_count_high = {4'h0, path_latch_r[11:8]}; // [RULE1]
  wire [7:0]  sync_loss_count_high  = {sync_latch_r[11:8], 4'h0}; // [RULE3]
  wire [7:0]  path_and_sync_count_high = sync_loss_count_high | path_error_count_high; // [RULE2]
  wire [7:0]  path_error_count_low  = path_latch_r[7:0]; // [RULE1]
  wire [7:0]  sync_loss_count_low   = sync_latch_r[7:0]; // [RULE3]
  wire [7:0]  rd_data =
    (wb_adr_i == tpsec_pkg::ADDR_HIGH)     ? path_and_sync_count_high :
    (wb_adr_i == tpsec_pkg::ADDR_PATH_LOW) ? path_error_count_low :
    (wb_adr_i == tpsec_pkg::ADDR_SYNC_LOW) ? sync_loss_count_low :
    (wb_adr_i == tpsec_pkg::ADDR_CTRL)     ? {4'h0, ctrl_r} :
    (wb_adr_i == tpsec_pkg::ADDR_INT_STAT) ? {5'h00, int_stat_r} :
    (wb_adr_i == tpsec_pkg::ADDR_INT_MASK) ? {5'h00, int_mask_r} : 8'h00;

  wire [2:0]  events    = {sync_sat, path_sat, tick};
  wire [2:0]  stat_clr  = wr_stat ? wb_dat_i[2:0] : 3'h0;
  logic [2:0] stat_nxt;

  // A new event wins over a write-one-to-clear in the same cycle.
  for (genvar b = 0; b < tpsec_pkg::IRQ_W; b++) begin : g_status
    assign stat_nxt[b] = events[b] || (int_stat_r[b] && !stat_clr[b]);
  end

  wire        irq_nxt   = |(stat_nxt & int_mask_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 8'h00;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r     <= tpsec_pkg::CTRL_RESET;
      int_mask_r <= tpsec_pkg::IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wb_dat_i[3:0];
      end
      if (wr_mask) begin
        int_mask_r <= wb_dat_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat_r <= tpsec_pkg::IRQ_RESET;
      irq_o      <= 1'b0;
      boundary_o <= 1'b0;
    end else begin
      int_stat_r <= stat_nxt;
      irq_o      <= irq_nxt;
      boundary_o <= tick;
    end
  end
endmodule : tpsec_top

/* File: design/tpsec_pkg.sv */
// Package of register map, field positions and timing counts for the T1 path and sync counters.
// Summary of operation
// [RULE1] Path error count is 12 bits: MSB at high byte bit 3, LSB low byte bit 0.
// [RULE2] Shared byte: sync-loss top nibble in upper half, path top nibble lower half.
// [RULE3] Sync-loss count is 12 bits: MSB at shared byte bit 7, LSB own low bit 0.
// [RULE4] In ESF mode path counter counts CRC6 code-word errors; Fs option ignored.
// [RULE5] In D4 mode path counter counts Ft errors, plus Fs errors when enabled.
// [RULE6] Source select one: count multiframes received while out of sync, either mode.
// [RULE7] Out-of-sync multiframe counting continues while sync loss flag is set.
// [RULE8] Source select zero: count Ft errors in D4, FPS errors in ESF.
// [RULE9] Framing-bit error counting stops while the sync loss flag is set.
// [RULE10] Path counter does not count while the sync loss flag is set.
// [RULE11] Readable values update each second, or every 42 ms when interval select set.
// [RULE12] Counters saturate at their maximum and never wrap.
// [RULE13] At each boundary running counts are copied to readable registers and cleared.
// [RULE14] Host reads all three bytes between boundaries and splits the shared byte.
package tpsec_pkg;
  localparam int unsigned CNT_W          = 12;
  localparam logic [11:0] CNT_MAX        = 12'hFFF;
  localparam logic [7:0]  ADDR_HIGH      = 8'h25;
  localparam logic [7:0]  ADDR_PATH_LOW  = 8'h26;
  localparam logic [7:0]  ADDR_SYNC_LOW  = 8'h27;
  localparam logic [7:0]  ADDR_CTRL      = 8'h28;
  localparam logic [7:0]  ADDR_INT_STAT  = 8'h29;
  localparam logic [7:0]  ADDR_INT_MASK  = 8'h2A;
  localparam int unsigned CTRL_FRAMING   = 0;
  localparam int unsigned CTRL_FS_EN     = 1;
  localparam int unsigned CTRL_SRC_SEL   = 2;
  localparam int unsigned CTRL_INTERVAL  = 3;
  localparam logic [3:0]  CTRL_RESET     = 4'h0;
  localparam int unsigned IRQ_BOUNDARY   = 0;
  localparam int unsigned IRQ_PATH_SAT   = 1;
  localparam int unsigned IRQ_SYNC_SAT   = 2;
  localparam int unsigned IRQ_W          = 3;
  localparam logic [2:0]  IRQ_RESET      = 3'h0;
  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned LONG_MS        = 1000;
  localparam int unsigned SHORT_MS       = 42;
  localparam int unsigned LONG_CYCLES    = CLK_HZ / 1000 * LONG_MS;
  localparam int unsigned SHORT_CYCLES   = CLK_HZ / 1000 * SHORT_MS;
endpackage : tpsec_pkg

/* File: design/tpsec_sat_counter.sv */
// Saturating 12-bit event counter that restarts from the boundary.
`timescale 1ns/1ps
module tpsec_sat_counter (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        inc_i,
  input  wire logic        clear_i,
  output logic [11:0]      count_o,
  output logic             sat_o
);
  logic [11:0] count_r;
  wire         at_max = (count_r == tpsec_pkg::CNT_MAX);
  // A boundary clear with a same-cycle event starts the new interval at one.
  wire  [11:0] count_nxt = clear_i ? {11'h000, inc_i} :
                           (inc_i && !at_max) ? count_r + 12'h001 : count_r; // [RULE12]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= 12'h000;
    end else begin
      count_r <= count_nxt;
    end
  end
  assign count_o = count_r;
  assign sat_o   = inc_i && at_max && !clear_i;
endmodule : tpsec_sat_counter

/* File: design/tpsec_interval_timer.sv */
// Interval timer producing a one-cycle boundary pulse every second or every 42 ms.
`timescale 1ns/1ps
module tpsec_interval_timer #(
  parameter int unsigned LONG_CYCLES  = tpsec_pkg::LONG_CYCLES,
  parameter int unsigned SHORT_CYCLES = tpsec_pkg::SHORT_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic short_i,
  output logic      tick_o
);
  logic [31:0] cnt_r;
  wire  [31:0] limit = short_i ? 32'(SHORT_CYCLES - 1) : 32'(LONG_CYCLES - 1); // [RULE11]
  // Switching to the shorter interval mid-count ends the current one at once if the count is already at or past the short limit.
  wire         done  = (cnt_r >= limit);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= done ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
      tick_o <= done;
    end
  end
endmodule : tpsec_interval_timer

/* File: tb/tpsec_props.sv */
// Checker of bus handshake, read data and boundary timing at the counter block ports.
`timescale 1ns/1ps
module tpsec_props #(
  parameter int unsigned LONG_CYCLES  = 200,
  parameter int unsigned SHORT_CYCLES = 50
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [0:0] wb_sel_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic       wb_ack_o,
  input wire logic       crc6_error_i,
  input wire logic       ft_error_i,
  input wire logic       fs_error_i,
  input wire logic       fps_error_i,
  input wire logic       rx_multiframe_i,
  input wire logic       receive_sync_loss_flag_i,
  input wire logic       boundary_o,
  input wire logic       irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since the last boundary; a stuck interval timer lets it run past the long interval.
  int unsigned gap_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_r <= 32'h0000_0000;
    end else begin
      gap_r <= boundary_o ? 32'h0000_0000 : gap_r + 32'h0000_0001;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 8'h00) else $error("data idle");
  AST_UNMAPPED: assert property (s_rd ##0 (wb_adr_i > 8'h2A) |=> wb_dat_o == 8'h00)
    else $error("unmapped data");
  AST_CTRL_RB: assert property (s_rd ##0 (wb_adr_i == 8'h28) |=> wb_dat_o[7:4] == 4'h0)
    else $error("control spare bits");
  AST_STAT_RB: assert property (s_rd ##0 (wb_adr_i == 8'h29) |=> wb_dat_o[7:3] == 5'h00)
    else $error("status spare bits");
  AST_BND_PULSE: assert property (boundary_o |=> !boundary_o) else $error("boundary held");
  AST_BND_DUE: assert property (gap_r <= LONG_CYCLES + 1) else $error("boundary overdue");
endmodule : tpsec_props
bind tpsec_top tpsec_props #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .crc6_error_i(crc6_error_i), .ft_error_i(ft_error_i),
  .fs_error_i(fs_error_i), .fps_error_i(fps_error_i), .rx_multiframe_i(rx_multiframe_i),
  .receive_sync_loss_flag_i(receive_sync_loss_flag_i), .boundary_o(boundary_o), .irq_o(irq_o));

/* File: tb/tpsec_framer_model.sv */
// Behavioural receive framer issuing bursts of error and multiframe strobes and the sync flag.
`timescale 1ns/1ps
module tpsec_framer_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic        loss_i,
  input  wire logic [4:0]  kind_i,
  input  wire logic [12:0] n_i,
  output logic [4:0]       strobe_o,
  output logic             sync_loss_o,
  output logic             busy_o
);
  logic [13:0] i_r;
  // Kind k repeats n_i + k times, so a count taken from the wrong source shows up.
  // Odd and even kinds take turns, as a real framer never flags Ft and Fs in one frame.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o      <= 1'b0;
      i_r         <= 14'h0000;
      strobe_o    <= 5'h00;
      sync_loss_o <= 1'b0;
    end else begin
      sync_loss_o <= loss_i;
      i_r         <= go_i ? 14'h0000 : i_r + 14'h0001;
      busy_o      <= go_i || (busy_o && i_r != {n_i + 13'h0004, 1'b0});
      for (int k = 0; k < 5; k++) begin
        strobe_o[k] <= busy_o && kind_i[k] && (i_r[0] == k[0]) && (i_r[13:1] < n_i + 13'(k));
      end
    end
  end
endmodule : tpsec_framer_model

/* File: tb/t1_path_and_sync_error_counters_tb.sv */
// Self-checking bench of the path and sync error counters.
`timescale 1ns/1ps
module t1_path_and_sync_error_counters_tb;
  typedef struct {logic [7:0] ctrl; logic loss; logic [11:0] p, s;} tpsec_row_s;
  tpsec_row_s rows [7] = '{'{8'h08, 1'b0, 12'h004, 12'h004}, '{8'h0A, 1'b0, 12'h009, 12'h004},
    '{8'h0B, 1'b0, 12'h003, 12'h006}, '{8'h0D, 1'b1, 12'h000, 12'h007},
    '{8'h0C, 1'b0, 12'h004, 12'h000}, '{8'h08, 1'b1, 12'h000, 12'h000},
    '{8'h09, 1'b0, 12'h003, 12'h006}};
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
  logic        loss = 1'b0, ack, bnd, irq, sl, busy;
  logic [0:0]  sel = 1'h1;
  logic [4:0]  kind = 5'h00, stb_v;
  logic [12:0] n = 13'h0000;
  logic [7:0]  adr = 8'h00, wdat = 8'h00, rdat, rd;
  int          n_mismatch = 0, check_count = 0, cyc_cnt = 0, gap = 0;
  initial forever #12.5 clk_i = ~clk_i;
  tpsec_top #(.LONG_CYCLES(10000), .SHORT_CYCLES(50)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .crc6_error_i(stb_v[0]),
    .ft_error_i(stb_v[1]), .fs_error_i(stb_v[2]), .fps_error_i(stb_v[3]),
    .rx_multiframe_i(stb_v[4]), .receive_sync_loss_flag_i(sl), .boundary_o(bnd), .irq_o(irq));
  tpsec_framer_model u_far (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .loss_i(loss),
    .kind_i(kind), .n_i(n), .strobe_o(stb_v), .sync_loss_o(sl), .busy_o(busy));
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [0:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, s};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00, 1'h1);
    chk(rd, exp);
  endtask : rdchk
  task automatic wait_bnd;
    do @(posedge clk_i); while (bnd !== 1'b1);
  endtask : wait_bnd
  task automatic burst(input logic [4:0] k, input logic [12:0] c);
    @(posedge clk_i);
    {kind, n, go} <= {k, c, 1'b1};
    @(posedge clk_i);
    go <= 1'b0;
    do @(posedge clk_i); while (busy === 1'b1);
  endtask : burst
  // The watchdog covers one long interval plus every short-interval row with margin.
  always @(posedge clk_i) begin
    cyc_cnt++;
    gap <= (bnd === 1'b1) ? 1 : gap + 1;
    if (cyc_cnt == 30000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (logic [7:0] a = 8'h25; a < 8'h2B; a++) rdchk(a, 8'h00);
    burst(5'h02, 13'h1004);
    wait_bnd();
    rdchk(8'h25, 8'hFF);
    rdchk(8'h26, 8'hFF);
    rdchk(8'h27, 8'hFF);
    rdchk(8'h29, 8'h07);
    chk({7'h00, irq}, 8'h00);
    wb(1'b1, 8'h2A, 8'h02, 1'h1);
    // The mask lands at the ack edge and the registered interrupt follows one edge later.
    repeat (2) @(posedge clk_i);
    chk({7'h00, irq}, 8'h01);
    wb(1'b1, 8'h29, 8'h07, 1'h1);
    @(posedge clk_i);
    chk({7'h00, irq}, 8'h00);
    wb(1'b1, 8'h28, 8'h08, 1'h1);
    foreach (rows[i]) begin
      wait_bnd();
      wb(1'b1, 8'h28, rows[i].ctrl, 1'h1);
      loss <= rows[i].loss;
      burst(5'h1F, 13'h0003);
      wait_bnd();
      chk(8'(gap), 8'h32);
      rdchk(8'h25, {rows[i].s[11:8], rows[i].p[11:8]});
      rdchk(8'h26, rows[i].p[7:0]);
      rdchk(8'h27, rows[i].s[7:0]);
    end
    rdchk(8'h30, 8'h00);
    wb(1'b1, 8'h26, 8'h5A, 1'h1);
    rdchk(8'h26, 8'h03);
    wb(1'b1, 8'h28, 8'h00, 1'h0);
    rdchk(8'h28, 8'h09);
    test_done();
  end
endmodule : t1_path_and_sync_error_counters_tb
